// ### bench/fps_chassis_model.sv
`timescale 1ns/100ps
// chassis side: two push-buttons on pull-ups, and a supply that follows toggle requests
module fps_chassis_model (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic pwr_press_i,             // operator holds the power button
   input  wire logic rst_press_i,             // operator holds the reset button
   input  wire logic bounce_i,                // contacts chatter just after closing
   input  wire logic psu_toggle_i,            // toggle request from the board
   output logic      power_button_sense_n_o,
   output logic      reset_button_sense_n_o,
   output logic      supply_live_o
);
   logic [2:0] pwr_age_ff;                    // cycles since power closure, saturating
   logic [2:0] rst_age_ff;                    // cycles since reset closure, saturating

   // closure age: chatter is only allowed in the first few cycles of a closure
   always_ff @(posedge ref_clk_i) begin
      pwr_age_ff <= !pwr_press_i ? 3'h0 : (pwr_age_ff == 3'h7) ? pwr_age_ff : pwr_age_ff + 3'h1;
      rst_age_ff <= !rst_press_i ? 3'h0 : (rst_age_ff == 3'h7) ? rst_age_ff : rst_age_ff + 3'h1;
   end

   // open contact reads high through the pull-up, closed contact shorts to ground
   assign power_button_sense_n_o = !pwr_press_i
      || (bounce_i && pwr_age_ff < 3'h4 && pwr_age_ff[0]);
   assign reset_button_sense_n_o = !rst_press_i
      || (bounce_i && rst_age_ff < 3'h4 && rst_age_ff[0]);

   // supply flips on every request; it has no lock-out of its own, so it trusts the board
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         supply_live_o <= 1'b0;
      end else if (psu_toggle_i) begin
         supply_live_o <= !supply_live_o;
      end
   end
endmodule : fps_chassis_model

// ### bench/fps_top_tb.sv
`timescale 1ns/100ps
// front panel bench: short counts, button corner cases and random lamp traffic
module fps_top_tb;
   localparam int unsigned HOLD  = 8;         // power hold, cycles
   localparam int unsigned LOCK  = 40;        // lock-out, cycles
   localparam int unsigned HALF  = 6;         // blink half period
   localparam int unsigned DEB   = 5;         // reset debounce
   localparam int unsigned PULSE = 4;         // board reset width

   logic                  ref_clk_i = 1'b0;
   logic                  rst_i     = 1'b1;
   logic                  clk_en_i  = 1'b1;   // low only in the freeze test
   logic                  pwr_press = 1'b0;
   logic                  rst_press = 1'b0;
   logic                  bounce    = 1'b0;
   logic                  disk_active_i = 1'b0;
   logic                  scsi_active_i = 1'b0;
   logic                  message_waiting_i = 1'b0;
   fps_pkg::fps_acpi_type acpi_state_i = fps_pkg::FPS_S5;
   logic                  pwr_n, rst_n, supply_live, reset_prev;
   logic                  psu_on, psu_toggle, board_reset, post_start, disk_lamp;
   logic                  green, yellow, green_s, yellow_s;
   logic                  on_exp;             // supply state the bench expects
   int                    bad_count  = 0;
   int                    n_compared = 0;
   int                    toggles, resets, reset_hi, posts;

   // 40 MHz reference
   always #12.5 ref_clk_i = !ref_clk_i;

   fps_chassis_model chassis (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pwr_press_i(pwr_press),
      .rst_press_i(rst_press), .bounce_i(bounce), .psu_toggle_i(psu_toggle),
      .power_button_sense_n_o(pwr_n), .reset_button_sense_n_o(rst_n),
      .supply_live_o(supply_live));

   // dual-colour lamp, the full controller
   fps_top #(.PWR_HOLD_CYC(HOLD), .LOCKOUT_CYC(LOCK), .BLINK_HALF_CYC(HALF),
      .RST_DEB_CYC(DEB), .RST_PULSE_CYC(PULSE), .DUAL_COLOUR(1'b1)) dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .power_button_sense_n_i(pwr_n), .reset_button_sense_n_i(rst_n),
      .disk_active_i(disk_active_i), .scsi_active_i(scsi_active_i),
      .acpi_state_i(acpi_state_i), .message_waiting_i(message_waiting_i),
      .psu_on_o(psu_on), .psu_toggle_o(psu_toggle), .board_reset_o(board_reset),
      .post_start_o(post_start), .disk_lamp_on_o(disk_lamp),
      .state_lamp_green_o(green), .state_lamp_yellow_o(yellow));

   // single-colour build on the same inputs; only its lamps are judged
   fps_top #(.PWR_HOLD_CYC(HOLD), .LOCKOUT_CYC(LOCK), .BLINK_HALF_CYC(HALF),
      .RST_DEB_CYC(DEB), .RST_PULSE_CYC(PULSE), .DUAL_COLOUR(1'b0)) dut_single (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .power_button_sense_n_i(pwr_n), .reset_button_sense_n_i(rst_n),
      .disk_active_i(disk_active_i), .scsi_active_i(scsi_active_i),
      .acpi_state_i(acpi_state_i), .message_waiting_i(message_waiting_i),
      .psu_on_o(), .psu_toggle_o(), .board_reset_o(), .post_start_o(),
      .disk_lamp_on_o(), .state_lamp_green_o(green_s), .state_lamp_yellow_o(yellow_s));

   // event counters on settled outputs; a post pulse away from a reset fall is marked big
   always @(negedge ref_clk_i) begin
      toggles  += (psu_toggle !== 1'b0);
      reset_hi += (board_reset !== 1'b0);
      resets   += (board_reset === 1'b1 && reset_prev === 1'b0);
      posts    += (post_start !== 1'b0);
      if (post_start === 1'b1 && !(reset_prev === 1'b1 && board_reset === 1'b0)) begin
         posts += 100;
      end
      reset_prev = board_reset;
   end

   task automatic chk1(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   task automatic chkn(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         bad_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chkn

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : idle

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   // hold the power button, then release long enough for the release to debounce
   task automatic pwr_hold(input int hold, input bit acc, input string name);
      int first;
      first   = -1;
      toggles = 0;
      pwr_press <= 1'b1;
      for (int i = 0; i < hold; i++) begin
         @(negedge ref_clk_i);
         if (psu_toggle === 1'b1 && first < 0) first = i;
         @(posedge ref_clk_i);
      end
      pwr_press <= 1'b0;
      idle(HOLD + 6);
      chkn("power toggles", int'(acc), toggles);
      if (acc) chk1("toggle timing", 1'b1, first >= HOLD && first <= HOLD + 5);
      on_exp ^= acc;
      chk1("supply request", on_exp, psu_on);
      chk1("supply follows", on_exp, supply_live);
      $display("test %s done", name);
   endtask : pwr_hold

   // hold the reset button long, so a held button must still give one reset
   task automatic rst_hold(input bit chatter, input bit acc, input string name);
      resets = 0;
      reset_hi = 0;
      posts = 0;
      bounce <= chatter;
      rst_press <= 1'b1;
      idle(30);
      rst_press <= 1'b0;
      bounce <= 1'b0;
      idle(DEB + 8);
      chkn("board resets", int'(acc), resets);
      chkn("reset width", acc ? int'(PULSE) : 0, reset_hi);
      chkn("self-test starts", int'(acc), posts);
      $display("test %s done", name);
   endtask : rst_hold

   // lamp colours lit steadily without a message: {green, yellow}
   function automatic logic [1:0] lamp_exp(input fps_pkg::fps_acpi_type s, input bit dual);
      case (s)
         fps_pkg::FPS_S0: return 2'h2;
         fps_pkg::FPS_S5: return 2'h0;
         default:         return {1'b0, dual};
      endcase
   endfunction : lamp_exp

   initial begin
      int          cnt [4];
      logic [1:0]  e, es;
      void'($urandom(32'h2DEA));
      on_exp = 1'b0;
      idle(10);
      rst_i <= 1'b0;
      @(negedge ref_clk_i);
      chk1("supply after reset", 1'b0, psu_on);
      chk1("reset after reset", 1'b0, board_reset);
      rst_hold(1'b0, 1'b0, "reset while off");
      pwr_hold(HOLD - 3, 1'b0, "short power press");
      pwr_hold(HOLD + 8, 1'b1, "power on");
      pwr_hold(HOLD + 8, 1'b0, "press in lock-out");
      idle(LOCK);
      pwr_hold(HOLD + 8, 1'b1, "power off");
      idle(LOCK);
      pwr_hold(HOLD + 8, 1'b1, "power on again");
      rst_hold(1'b1, 1'b1, "bouncing reset");
      rst_hold(1'b0, 1'b1, "clean reset");
      // random lamp traffic, steady colours only
      for (int k = 0; k < 150; k++) begin
         @(posedge ref_clk_i);
         disk_active_i <= 1'($urandom);
         scsi_active_i <= 1'($urandom);
         acpi_state_i <= fps_pkg::fps_acpi_type'(2'($urandom));
         message_waiting_i <= 1'b0;
         idle(1);
         @(negedge ref_clk_i);
         e  = lamp_exp(acpi_state_i, 1'b1);
         es = lamp_exp(acpi_state_i, 1'b0);
         chk1("disk lamp", disk_active_i | scsi_active_i, disk_lamp);
         chk1("green lamp", e[1], green);
         chk1("yellow lamp", e[0], yellow);
         chk1("single green", es[1], green_s);
         chk1("single yellow", es[0], yellow_s);
      end
      $display("test steady lamps done");
      // clock enable low freezes the lamps; they catch up once it returns
      @(posedge ref_clk_i);
      acpi_state_i <= fps_pkg::FPS_S0;
      disk_active_i <= 1'b1;
      scsi_active_i <= 1'b0;
      idle(2);
      clk_en_i <= 1'b0;
      acpi_state_i <= fps_pkg::FPS_S5;
      disk_active_i <= 1'b0;
      idle(5);
      @(negedge ref_clk_i);
      chk1("frozen green", 1'b1, green);
      chk1("frozen disk lamp", 1'b1, disk_lamp);
      @(posedge ref_clk_i);
      clk_en_i <= 1'b1;
      idle(1);
      @(negedge ref_clk_i);
      chk1("thawed green", 1'b0, green);
      chk1("thawed disk lamp", 1'b0, disk_lamp);
      $display("test clock enable done");
      // message waiting in every state: two whole blink periods hold exactly half lit
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk_i);
         acpi_state_i <= fps_pkg::fps_acpi_type'(2'(s));
         message_waiting_i <= 1'b1;
         idle(2);
         cnt = '{0, 0, 0, 0};
         repeat (4 * HALF) begin
            @(negedge ref_clk_i);
            cnt[0] += (green !== 1'b0);
            cnt[1] += (yellow !== 1'b0);
            cnt[2] += (green_s !== 1'b0);
            cnt[3] += (yellow_s !== 1'b0);
         end
         e  = lamp_exp(acpi_state_i, 1'b1);
         es = lamp_exp(acpi_state_i, 1'b0);
         chkn("blink green", e[1] ? int'(2 * HALF) : 0, cnt[0]);
         chkn("blink yellow", e[0] ? int'(2 * HALF) : 0, cnt[1]);
         chkn("single blink green", es[1] ? int'(2 * HALF) : 0, cnt[2]);
         chkn("single blink yellow", 0, cnt[3]);
      end
      $display("test message blink done");
      end_sim();
   end

   // hang guard far beyond the run: 100000 cycles against under 1000 used
   initial begin
      #2500000;
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      end_sim();
   end
endmodule : fps_top_tb

// ### rtl/fps_blink.sv
`timescale 1ns/100ps
// free-running square wave for the message-waiting blink
module fps_blink #(
   parameter int unsigned HALF_CYC = 32'h0000_0010
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic clk_en_i,
   output logic      phase_o
);

   logic [31:0] cnt_ff;    // cycles spent in the current phase
   logic        phase_ff;  // high in the lit half

   // equal halves give the 50 percent duty
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_ff   <= 32'h0;
         phase_ff <= 1'b1;
      end else if (clk_en_i) begin
         if (cnt_ff == HALF_CYC - 32'h1) begin
            cnt_ff   <= 32'h0;
            phase_ff <= ~phase_ff;
         end else begin
            cnt_ff <= cnt_ff + 32'h1;
         end
      end
   end

   assign phase_o = phase_ff;

   property p_half_period;
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(phase_ff) |-> $past(cnt_ff) == HALF_CYC - 32'h1;
   endproperty
   a_half_period : assert property (p_half_period)
      else $error("blink phase changed off the half period");

endmodule : fps_blink

// ### rtl/fps_debounce.sv
`timescale 1ns/100ps
// synchronises an active-low button and qualifies it by a stable time
module fps_debounce #(
   parameter int unsigned HOLD_CYC = 32'h0000_0010
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic clk_en_i,
   input  wire logic button_n_i,
   output logic      pressed_o,
   output logic      press_o
);

   logic        sync_a_ff;   // first synchroniser stage, read only by the second
   logic        sync_b_ff;   // second stage, safe to use
   logic [31:0] cnt_ff;      // cycles the input has differed from the held level
   logic        pressed_ff;  // debounced level, high while button closed
   logic        press_ff;    // one-cycle pulse on a qualified closure

   // two-flop synchroniser; open button idles high through its pull-up
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync_a_ff <= 1'b1;
         sync_b_ff <= 1'b1;
      end else if (clk_en_i) begin
         sync_a_ff <= button_n_i;
         sync_b_ff <= sync_a_ff;
      end
   end

   // level must differ for HOLD_CYC cycles in a row before it is taken;
   // any bounce back restarts the count, so short closures never pass
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_ff     <= 32'h0;
         pressed_ff <= 1'b0;
         press_ff   <= 1'b0;
      end else if (clk_en_i) begin
         press_ff <= 1'b0;
         if (~sync_b_ff != pressed_ff) begin
            if (cnt_ff == HOLD_CYC - 32'h1) begin
               cnt_ff     <= 32'h0;
               pressed_ff <= ~sync_b_ff;
               press_ff   <= ~sync_b_ff;
            end else begin
               cnt_ff <= cnt_ff + 32'h1;
            end
         end else begin
            cnt_ff <= 32'h0;
         end
      end
   end

   assign pressed_o = pressed_ff;
   assign press_o   = press_ff;

   property p_press_needs_low;
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(press_ff) |-> pressed_ff && !$past(sync_b_ff) && $past(cnt_ff) == HOLD_CYC - 32'h1;
   endproperty
   a_press_needs_low : assert property (p_press_needs_low)
      else $error("press taken without the full low hold");

   property p_level_change_qualified;
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(pressed_ff) |-> $past(clk_en_i) && $past(cnt_ff) == HOLD_CYC - 32'h1;
   endproperty
   a_level_change_qualified : assert property (p_level_change_qualified)
      else $error("debounced level changed before the hold time");

endmodule : fps_debounce

// ### rtl/fps_params.svh
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// clock rate in kHz, so that ms * kHz gives whole cycles
`define FPS_CLK_KHZ          40000

// least hold time of the power button, in ms
`define FPS_PWR_HOLD_MS      50
`define FPS_PWR_HOLD_CYC     (`FPS_PWR_HOLD_MS * `FPS_CLK_KHZ)

// least lock-out after an accepted power request, in ms
`define FPS_LOCKOUT_MS       2000
`define FPS_LOCKOUT_CYC      (`FPS_LOCKOUT_MS * `FPS_CLK_KHZ)

// full blink period of the state lamp, in ms; half of it per phase
`define FPS_BLINK_PERIOD_MS  1000
`define FPS_BLINK_HALF_CYC   ((`FPS_BLINK_PERIOD_MS * `FPS_CLK_KHZ) / 2)

// stable time the reset button needs before it counts, in ms
`define FPS_RST_DEB_MS       10
`define FPS_RST_DEB_CYC      (`FPS_RST_DEB_MS * `FPS_CLK_KHZ)

// least width of the board reset pulse, in us, rounded up to cycles
`define FPS_RST_PULSE_US     100
`define FPS_RST_PULSE_CYC    ((`FPS_RST_PULSE_US * `FPS_CLK_KHZ + 999) / 1000)

`endif

// ### rtl/fps_pkg.sv
package fps_pkg;

   // system sleep state as reported by the power manager
   typedef enum logic [1:0] {
      FPS_S0,
      FPS_S1,
      FPS_S3,
      FPS_S5
   } fps_acpi_type;

   // power request sequencer
   typedef enum logic {
      FPS_PWR_READY,
      FPS_PWR_LOCKOUT
   } fps_pwr_state_type;

   // board reset sequencer
   typedef enum logic [1:0] {
      FPS_RST_IDLE,
      FPS_RST_DRIVE,
      FPS_RST_RELEASE
   } fps_rst_state_type;

endpackage : fps_pkg

// ### rtl/fps_top.sv
`timescale 1ns/100ps
`include "fps_params.svh"
// front panel switch and lamp controller on the standby clock
module fps_top #(
   parameter int unsigned PWR_HOLD_CYC   = `FPS_PWR_HOLD_CYC,
   parameter int unsigned LOCKOUT_CYC    = `FPS_LOCKOUT_CYC,
   parameter int unsigned BLINK_HALF_CYC = `FPS_BLINK_HALF_CYC,
   parameter int unsigned RST_DEB_CYC    = `FPS_RST_DEB_CYC,
   parameter int unsigned RST_PULSE_CYC  = `FPS_RST_PULSE_CYC,
   parameter bit          DUAL_COLOUR    = 1'b1
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  power_button_sense_n_i,
   input  wire logic                  reset_button_sense_n_i,
   input  wire logic                  disk_active_i,
   input  wire logic                  scsi_active_i,
   input  wire fps_pkg::fps_acpi_type acpi_state_i,
   input  wire logic                  message_waiting_i,
   output logic                       psu_on_o,
   output logic                       psu_toggle_o,
   output logic                       board_reset_o,
   output logic                       post_start_o,
   output logic                       disk_lamp_on_o,
   output logic                       state_lamp_green_o,
   output logic                       state_lamp_yellow_o
);

   // debounced button views and the blink phase
   logic                       pwr_pressed;   // power button held, debounced
   logic                       pwr_press;     // one pulse per qualified press
   logic                       rst_pressed;   // reset button held, debounced
   logic                       rst_press;     // one pulse per debounced press
   logic                       blink_phase;   // lit half of the blink

   // power request state
   fps_pkg::fps_pwr_state_type pwr_state_ff;  // ready or locked out
   logic [31:0]                lock_cnt_ff;   // cycles spent in lock-out
   logic                       psu_on_ff;     // requested supply state
   logic                       psu_toggle_ff; // pulse per accepted request

   // board reset state
   fps_pkg::fps_rst_state_type rst_state_ff;  // reset sequencer
   logic [31:0]                rst_cnt_ff;    // width of the reset pulse
   logic                       board_reset_ff;
   logic                       post_start_ff; // pulse as the board leaves reset

   // lamp state
   logic                       disk_lamp_ff;
   logic                       green_ff;
   logic                       yellow_ff;

   // power button: active low, closure must last the full hold time
   fps_debounce #(
      .HOLD_CYC (PWR_HOLD_CYC)
   ) u_pwr_deb (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .clk_en_i   (clk_en_i),
      .button_n_i (power_button_sense_n_i),
      .pressed_o  (pwr_pressed),
      .press_o    (pwr_press)
   );

   // reset button: active low, bounce filtered so one press gives one reset
   fps_debounce #(
      .HOLD_CYC (RST_DEB_CYC)
   ) u_rst_deb (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .clk_en_i   (clk_en_i),
      .button_n_i (reset_button_sense_n_i),
      .pressed_o  (rst_pressed),
      .press_o    (rst_press)
   );

   // blink source for message waiting, shared by both lamp colours
   fps_blink #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clk_en_i  (clk_en_i),
      .phase_o   (blink_phase)
   );

   // power request sequencer: accept a press, then sit out the lock-out;
   // the press pulse fires only on closure, so a button still held when
   // the lock-out ends does not make a second request
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pwr_state_ff  <= fps_pkg::FPS_PWR_READY;
         lock_cnt_ff   <= 32'h0;
         psu_toggle_ff <= 1'b0;
      end else if (clk_en_i) begin
         psu_toggle_ff <= 1'b0;
         unique case (pwr_state_ff)
            fps_pkg::FPS_PWR_READY: begin
               // qualified press becomes a request
               if (pwr_press) begin
                  psu_toggle_ff <= 1'b1;
                  pwr_state_ff  <= fps_pkg::FPS_PWR_LOCKOUT;
                  lock_cnt_ff   <= 32'h0;
               end
            end
            fps_pkg::FPS_PWR_LOCKOUT: begin
               // presses here are dropped on purpose
               if (lock_cnt_ff == LOCKOUT_CYC - 32'h1) begin
                  pwr_state_ff <= fps_pkg::FPS_PWR_READY;
                  lock_cnt_ff  <= 32'h0;
               end else begin
                  lock_cnt_ff <= lock_cnt_ff + 32'h1;
               end
            end
         endcase
      end
   end

   // supply request level flips in the same edge the request is taken
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         psu_on_ff <= 1'b0;
      end else if (clk_en_i) begin
         if (pwr_state_ff == fps_pkg::FPS_PWR_READY && pwr_press) begin
            psu_on_ff <= ~psu_on_ff;
         end
      end
   end

   // board reset sequencer: fixed-width pulse, then wait for release so
   // a long press still yields a single reset; ignored with supply off
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rst_state_ff   <= fps_pkg::FPS_RST_IDLE;
         rst_cnt_ff     <= 32'h0;
         board_reset_ff <= 1'b0;
         post_start_ff  <= 1'b0;
      end else if (clk_en_i) begin
         post_start_ff <= 1'b0;
         unique case (rst_state_ff)
            fps_pkg::FPS_RST_IDLE: begin
               // debounced closure starts the reset
               if (rst_press && psu_on_ff) begin
                  board_reset_ff <= 1'b1;
                  rst_cnt_ff     <= 32'h0;
                  rst_state_ff   <= fps_pkg::FPS_RST_DRIVE;
               end
            end
            fps_pkg::FPS_RST_DRIVE: begin
               // hold reset, then let the board run self-test
               if (rst_cnt_ff == RST_PULSE_CYC - 32'h1) begin
                  board_reset_ff <= 1'b0;
                  post_start_ff  <= 1'b1;
                  rst_state_ff   <= fps_pkg::FPS_RST_RELEASE;
               end else begin
                  rst_cnt_ff <= rst_cnt_ff + 32'h1;
               end
            end
            fps_pkg::FPS_RST_RELEASE: begin
               // re-arm only after the button is let go
               if (!rst_pressed) begin
                  rst_state_ff <= fps_pkg::FPS_RST_IDLE;
               end
            end
            default: begin
               // the fourth code is unused; recover to idle
               rst_state_ff   <= fps_pkg::FPS_RST_IDLE;
               board_reset_ff <= 1'b0;
            end
         endcase
      end
   end

   // disk lamp follows either activity source, registered for a clean pin
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         disk_lamp_ff <= 1'b0;
      end else if (clk_en_i) begin
         disk_lamp_ff <= disk_active_i | scsi_active_i;
      end
   end

   // state lamp; a single-colour lamp has no yellow, so sleep shows dark
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         green_ff  <= 1'b0;
         yellow_ff <= 1'b0;
      end else if (clk_en_i) begin
         unique case (acpi_state_i)
            fps_pkg::FPS_S0: begin
               // running: steady, or blinking with a message
               green_ff  <= ~message_waiting_i | blink_phase;
               yellow_ff <= 1'b0;
            end
            fps_pkg::FPS_S1,
            fps_pkg::FPS_S3: begin
               // sleeping: yellow only on a dual-colour lamp
               green_ff  <= 1'b0;
               yellow_ff <= DUAL_COLOUR & (~message_waiting_i | blink_phase);
            end
            fps_pkg::FPS_S5: begin
               // powered off: dark
               green_ff  <= 1'b0;
               yellow_ff <= 1'b0;
            end
         endcase
      end
   end

   assign psu_on_o            = psu_on_ff;
   assign psu_toggle_o        = psu_toggle_ff;
   assign board_reset_o       = board_reset_ff;
   assign post_start_o        = post_start_ff;
   assign disk_lamp_on_o      = disk_lamp_ff;
   assign state_lamp_green_o  = green_ff;
   assign state_lamp_yellow_o = yellow_ff;

   property p_press_toggles;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pwr_press && pwr_state_ff == fps_pkg::FPS_PWR_READY)
         |=> psu_toggle_ff && psu_on_ff != $past(psu_on_ff)
             && pwr_state_ff == fps_pkg::FPS_PWR_LOCKOUT;
   endproperty
   a_press_toggles : assert property (p_press_toggles)
      else $error("qualified press did not toggle the supply");

   property p_lockout_full;
      @(posedge ref_clk_i) disable iff (rst_i)
      $changed(pwr_state_ff) && pwr_state_ff == fps_pkg::FPS_PWR_READY
         |-> $past(lock_cnt_ff) == LOCKOUT_CYC - 32'h1;
   endproperty
   a_lockout_full : assert property (p_lockout_full)
      else $error("lock-out ended early");

   property p_lockout_ignores;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pwr_state_ff == fps_pkg::FPS_PWR_LOCKOUT)
         |=> !psu_toggle_ff && $stable(psu_on_ff);
   endproperty
   a_lockout_ignores : assert property (p_lockout_ignores)
      else $error("power request accepted during lock-out");

   property p_reset_starts;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && rst_press && psu_on_ff && rst_state_ff == fps_pkg::FPS_RST_IDLE)
         |=> board_reset_ff ##0 (board_reset_ff [*2]);
   endproperty
   a_reset_starts : assert property (p_reset_starts)
      else $error("reset press did not hold the board in reset");

   property p_post_after_reset;
      @(posedge ref_clk_i) disable iff (rst_i)
      $rose(post_start_ff) |-> $past(board_reset_ff) && !board_reset_ff
         && $past(rst_cnt_ff) == RST_PULSE_CYC - 32'h1;
   endproperty
   a_post_after_reset : assert property (p_post_after_reset)
      else $error("self-test start not at the end of reset");

   property p_disk_lamp;
      @(posedge ref_clk_i) disable iff (rst_i)
      clk_en_i |=> disk_lamp_ff == ($past(disk_active_i) | $past(scsi_active_i));
   endproperty
   a_disk_lamp : assert property (p_disk_lamp)
      else $error("disk lamp does not follow activity");

   property p_scsi_lamp;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && scsi_active_i) |=> disk_lamp_ff;
   endproperty
   a_scsi_lamp : assert property (p_scsi_lamp)
      else $error("scsi activity not shown on the disk lamp");

   property p_dark_unless_running;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && acpi_state_i != fps_pkg::FPS_S0) |=> !green_ff;
   endproperty
   a_dark_unless_running : assert property (p_dark_unless_running)
      else $error("green lamp lit outside the running state");

   property p_running_steady;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && acpi_state_i == fps_pkg::FPS_S0 && !message_waiting_i)
         |=> green_ff && !yellow_ff;
   endproperty
   a_running_steady : assert property (p_running_steady)
      else $error("running without message is not steady green");

   // a waiting message makes the running lamp follow the blink phase
   property p_running_blinks;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && acpi_state_i == fps_pkg::FPS_S0 && message_waiting_i)
         |=> green_ff == $past(blink_phase) && !yellow_ff;
   endproperty
   a_running_blinks : assert property (p_running_blinks)
      else $error("running with a message does not blink green");

   property p_sleep_colour;
      @(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && (acpi_state_i == fps_pkg::FPS_S1 || acpi_state_i == fps_pkg::FPS_S3)
         && !message_waiting_i) |=> yellow_ff == DUAL_COLOUR;
   endproperty
   a_sleep_colour : assert property (p_sleep_colour)
      else $error("sleep colour does not match the lamp type");

endmodule : fps_top
